// ---- serial_eeprom_pkg.sv ----
// constants shared by the two-wire serial memory slave
package serial_eeprom_pkg;
  // array geometry
  localparam int MEM_BYTES = 2048;
  localparam int ADDR_W = 11;
  localparam int PAGE_BYTES = 16;
  localparam int PAGE_W = 4;
  localparam int BLOCK_W = 3;
  // slave address byte layout
  localparam logic [3:0] TYPE_ARRAY = 4'hA;   // 1010 main array
  localparam logic [3:0] TYPE_IDPAGE = 4'hB;  // 1011 identification page
  localparam int TYPE_MSB = 7;
  localparam int TYPE_LSB = 4;
  localparam int BLOCK_MSB = 3;
  localparam int BLOCK_LSB = 1;
  localparam int DIR_BIT = 0;
  localparam logic DIR_READ = 1'b1;
  // bits per byte and the acknowledge clock index
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // reset values
  localparam logic [10:0] ADDR_RST = 11'h000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  // self-timed write cycle, longest time
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_WRITE_NS = 4000000;
  localparam int WRITE_CYCLES = T_WRITE_NS / CLK_PERIOD_NS;
  // protocol states
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b000,   // standby, waiting for start
    ST_ADDR = 3'b001,   // receiving slave address
    ST_WORD = 3'b010,   // receiving byte address
    ST_DATA = 3'b011,   // receiving write data
    ST_READ = 3'b100,   // sending read data
    ST_PROG = 3'b101    // internal write cycle, deaf
  } bus_state_e;
endpackage

// ---- serial_eeprom_bus_slave.sv ----
// two-wire bus slave front end of a 2048-byte serial memory
`timescale 1ns/10ps
module serial_eeprom_bus_slave
#(
  // self-timed write cycle in clk_sys cycles
  parameter int WRITE_CYCLES = serial_eeprom_pkg::WRITE_CYCLES
)
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic write_protect,
  output logic standby,
  output logic write_busy
);
  localparam int CNT_W = $clog2(WRITE_CYCLES + 1);
  // the commit walk needs one cycle per page position
  generate
    if (WRITE_CYCLES < serial_eeprom_pkg::PAGE_BYTES + 1)
    begin : g_check
      $error("WRITE_CYCLES too small for page commit");
    end
  endgenerate
  // link clock domain: one sampled bit per rising scl
  logic bit_tog_reg; // flips on each rising scl
  logic bit_val_reg; // data level at that edge
  // sample data while the clock is high
  always_ff @(posedge scl or negedge resetn)
  begin
    if (!resetn)
    begin
      bit_tog_reg <= 1'b0;
      bit_val_reg <= 1'b0;
    end
    else
    begin
      bit_tog_reg <= ~bit_tog_reg;
      bit_val_reg <= sda_in;
    end
  end
  // synchronisers into clk_sys
  logic scl_s1_reg, scl_s2_reg, scl_s3_reg;
  logic sda_s1_reg, sda_s2_reg, sda_s3_reg;
  logic tog_s1_reg, tog_s2_reg, tog_s3_reg;
  logic wp_s1_reg, wp_s2_reg;
  // two flops per crossing, third only for edges
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      scl_s1_reg <= 1'b1;
      scl_s2_reg <= 1'b1;
      scl_s3_reg <= 1'b1;
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
      sda_s3_reg <= 1'b1;
      tog_s1_reg <= 1'b0;
      tog_s2_reg <= 1'b0;
      tog_s3_reg <= 1'b0;
      wp_s1_reg <= 1'b0;
      wp_s2_reg <= 1'b0;
    end
    else
    begin
      scl_s1_reg <= scl;
      scl_s2_reg <= scl_s1_reg;
      scl_s3_reg <= scl_s2_reg;
      sda_s1_reg <= sda_in;
      sda_s2_reg <= sda_s1_reg;
      sda_s3_reg <= sda_s2_reg;
      tog_s1_reg <= bit_tog_reg;
      tog_s2_reg <= tog_s1_reg;
      tog_s3_reg <= tog_s2_reg;
      wp_s1_reg <= write_protect;
      wp_s2_reg <= wp_s1_reg;
    end
  end
  // bus events seen in clk_sys
  logic scl_high; // clock high on both sampled cycles
  logic start_ev; // data falls while clock high
  logic stop_ev; // data rises while clock high
  logic rise_ev; // a bit was sampled on the link
  logic fall_ev; // clock fell, time to drive data
  // both lines share the same delay, so edges keep order
  assign scl_high = scl_s2_reg & scl_s3_reg;
  assign start_ev = scl_high & sda_s3_reg & ~sda_s2_reg;
  assign stop_ev = scl_high & ~sda_s3_reg & sda_s2_reg;
  assign rise_ev = tog_s2_reg ^ tog_s3_reg;
  assign fall_ev = scl_s3_reg & ~scl_s2_reg;
  logic [7:0] mem [serial_eeprom_pkg::MEM_BYTES]; // main array
  logic [7:0] id_mem [serial_eeprom_pkg::PAGE_BYTES]; // id page
  logic [7:0] page_buf [serial_eeprom_pkg::PAGE_BYTES]; // write buffer
  // protocol state
  serial_eeprom_pkg::bus_state_e state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next; // bits seen in this byte
  logic [7:0] shift_reg, shift_next; // received bits
  logic ack_reg, ack_next; // acknowledge due on ninth clock
  logic oe_reg, oe_next; // pulling data low
  logic [10:0] addr_reg, addr_next; // internal address counter
  logic [2:0] blk_reg, blk_next; // block bits from address byte
  logic idsel_reg, idsel_next; // id page selected
  logic [7:0] tx_reg, tx_next; // byte being sent
  logic [15:0] valid_reg, valid_next; // buffered page positions
  logic [CNT_W-1:0] prog_reg, prog_next; // write cycle timer
  logic standby_reg, standby_next;
  logic busy_reg, busy_next;
  logic [7:0] byte_in; // byte including the bit just sampled
  logic buf_we; // store byte into page buffer
  logic [3:0] commit_idx; // page position being committed
  logic commit_we; // commit position this cycle
  assign byte_in = {shift_reg[6:0], bit_val_reg};
  assign commit_idx = prog_reg[3:0];
  // next-state computation for the bus engine
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    shift_next = shift_reg;
    ack_next = ack_reg;
    oe_next = oe_reg;
    addr_next = addr_reg;
    blk_next = blk_reg;
    idsel_next = idsel_reg;
    tx_next = tx_reg;
    valid_next = valid_reg;
    prog_next = prog_reg;
    buf_we = 1'b0;
    commit_we = 1'b0;
    if (state_reg == serial_eeprom_pkg::ST_PROG)
    begin
      // inputs disabled; walk page buffer, then wait out timer
      oe_next = 1'b0;
      commit_we = (prog_reg < CNT_W'(serial_eeprom_pkg::PAGE_BYTES))
                  & valid_reg[commit_idx];
      if (prog_reg == CNT_W'(WRITE_CYCLES - 1))
      begin
        // write done: back to standby
        state_next = serial_eeprom_pkg::ST_IDLE;
        valid_next = 16'h0000;
        prog_next = '0;
      end
      else
      begin
        prog_next = prog_reg + 1'b1;
      end
    end
    else if (start_ev)
    begin
      // start abandons any transfer under way
      state_next = serial_eeprom_pkg::ST_ADDR;
      cnt_next = 4'h0;
      ack_next = 1'b0;
      oe_next = 1'b0;
      valid_next = 16'h0000;
    end
    else if (stop_ev)
    begin
      oe_next = 1'b0;
      ack_next = 1'b0;
      if ((state_reg == serial_eeprom_pkg::ST_DATA) && (valid_reg != 16'h0)
          && !wp_s2_reg)
      begin
        // commit starts at stop
        state_next = serial_eeprom_pkg::ST_PROG;
        prog_next = '0;
      end
      else
      begin
        // non-write stop, or protected write, ends in standby
        state_next = serial_eeprom_pkg::ST_IDLE;
        valid_next = 16'h0000;
      end
    end
    else if (rise_ev && (state_reg != serial_eeprom_pkg::ST_IDLE))
    begin
      if (cnt_reg != serial_eeprom_pkg::BYTE_BITS)
      begin
        // one of the eight bits of a byte
        shift_next = byte_in;
        cnt_next = cnt_reg + 4'h1;
        if (cnt_reg == 4'h7)
        begin
          case (state_reg)
            serial_eeprom_pkg::ST_ADDR:
            begin
              // type bits decide whether we answer
              if (byte_in[7:4] == serial_eeprom_pkg::TYPE_ARRAY)
              begin
                ack_next = 1'b1;
                idsel_next = 1'b0;
                blk_next = byte_in[3:1];
              end
              else if (byte_in[7:4] == serial_eeprom_pkg::TYPE_IDPAGE)
              begin
                // block bits are don't care here
                ack_next = 1'b1;
                idsel_next = 1'b1;
              end
              else
              begin
                state_next = serial_eeprom_pkg::ST_IDLE;
              end
            end
            serial_eeprom_pkg::ST_WORD:
            begin
              addr_next = {blk_reg, byte_in};
              ack_next = 1'b1;
            end
            serial_eeprom_pkg::ST_DATA:
            begin
              // buffer, ack, bump low bits only
              buf_we = 1'b1;
              valid_next[addr_reg[3:0]] = 1'b1;
              addr_next = {addr_reg[10:4], addr_reg[3:0] + 4'h1};
              ack_next = 1'b1;
            end
            default:
            begin
              // sending: master owns the ninth clock
              ack_next = 1'b0;
            end
          endcase
        end
      end
      else
      begin
        // ninth clock: acknowledge phase ends
        cnt_next = 4'h0;
        ack_next = 1'b0;
        case (state_reg)
          serial_eeprom_pkg::ST_ADDR:
          begin
            if (shift_reg[0] == serial_eeprom_pkg::DIR_READ)
            begin
              // current address read
              state_next = serial_eeprom_pkg::ST_READ;
              tx_next = idsel_reg ? id_mem[addr_reg[3:0]] : mem[addr_reg];
            end
            else
            begin
              state_next = serial_eeprom_pkg::ST_WORD;
            end
          end
          serial_eeprom_pkg::ST_WORD:
          begin
            state_next = serial_eeprom_pkg::ST_DATA;
          end
          serial_eeprom_pkg::ST_READ:
          begin
            // no sequential read: stop sending, wait for stop
            state_next = serial_eeprom_pkg::ST_IDLE;
            addr_next = addr_reg + 11'h001;
          end
          default:
          begin
            state_next = state_reg;
          end
        endcase
      end
    end
    else if (fall_ev)
    begin
      // data changes only while clock is low
      if (cnt_reg == serial_eeprom_pkg::BYTE_BITS)
      begin
        oe_next = ack_reg;
      end
      else if (state_reg == serial_eeprom_pkg::ST_READ)
      begin
        // open drain: pull low for a zero bit
        oe_next = ~tx_reg[3'h7 - cnt_reg[2:0]];
      end
      else
      begin
        oe_next = 1'b0;
      end
    end
    standby_next = (state_next == serial_eeprom_pkg::ST_IDLE);
    busy_next = (state_next == serial_eeprom_pkg::ST_PROG);
  end
  // register the bus engine
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= serial_eeprom_pkg::ST_IDLE;
      cnt_reg <= 4'h0;
      shift_reg <= serial_eeprom_pkg::BYTE_RST;
      ack_reg <= 1'b0;
      oe_reg <= 1'b0;
      addr_reg <= serial_eeprom_pkg::ADDR_RST;
      blk_reg <= 3'h0;
      idsel_reg <= 1'b0;
      tx_reg <= serial_eeprom_pkg::BYTE_RST;
      valid_reg <= 16'h0000;
      prog_reg <= '0;
      standby_reg <= 1'b1;
      busy_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      shift_reg <= shift_next;
      ack_reg <= ack_next;
      oe_reg <= oe_next;
      addr_reg <= addr_next;
      blk_reg <= blk_next;
      idsel_reg <= idsel_next;
      tx_reg <= tx_next;
      valid_reg <= valid_next;
      prog_reg <= prog_next;
      standby_reg <= standby_next;
      busy_reg <= busy_next;
    end
  end
  // storage writes, no reset; later bytes overwrite earlier ones
  always_ff @(posedge clk_sys)
  begin
    if (buf_we)
    begin
      page_buf[addr_reg[3:0]] <= byte_in;
    end
    if (commit_we && idsel_reg)
    begin
      id_mem[commit_idx] <= page_buf[commit_idx];
    end
    else if (commit_we)
    begin
      mem[{addr_reg[10:4], commit_idx}] <= page_buf[commit_idx];
    end
  end
  // outputs straight from flops, sda_out tied to zero; the pin is only ever pulled low
  assign sda_oe = oe_reg;
  assign sda_out = 1'b0;
  assign standby = standby_reg;
  assign write_busy = busy_reg;
endmodule

// ---- eeprom_slave_sva.sv ----
// port assertions for the two-wire serial memory slave
`timescale 1ns/10ps
module eeprom_slave_sva
#(
  parameter int WRITE_CYCLES = serial_eeprom_pkg::WRITE_CYCLES
)
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic write_protect,
  input wire logic standby,
  input wire logic write_busy
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  int busy_cnt_reg; // cycles spent in the write cycle
  int busy_cnt_next;
  // busy length counter, too long for a repetition
  always_comb
  begin
    busy_cnt_next = write_busy ? busy_cnt_reg + 1 : 0;
  end
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      busy_cnt_reg <= 0;
    else
      busy_cnt_reg <= busy_cnt_next;
  end
  // data rises while the clock stays high
  sequence s_stop;
    scl && $past(scl) && $rose(sda_in);
  endsequence
  property p_open_drain;
    sda_oe |-> !sda_out;
  endproperty
  property p_busy_deaf;
    write_busy |-> !sda_oe;
  endproperty
  property p_busy_awake;
    write_busy |-> !standby;
  endproperty
  property p_oe_clk_low;
    $changed(sda_oe) |-> !scl && !$past(scl);
  endproperty
  property p_busy_min;
    $fell(write_busy) |-> $past(busy_cnt_reg) >= WRITE_CYCLES - 2;
  endproperty
  property p_busy_max;
    write_busy |-> busy_cnt_reg <= WRITE_CYCLES + 1;
  endproperty
  property p_busy_after_stop;
    $rose(write_busy) |-> scl && sda_in;
  endproperty
  property p_stop_idle;
    s_stop |-> ##[1:8] (standby || write_busy);
  endproperty
  property p_done_standby;
    $fell(write_busy) |-> ##[0:1] standby;
  endproperty
  property p_drive_selected;
    sda_oe |-> !standby;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("data driven high");
  a_busy_deaf: assert property (p_busy_deaf)
    else $error("answer during write cycle");
  a_busy_awake: assert property (p_busy_awake)
    else $error("standby during write cycle");
  a_oe_clk_low: assert property (p_oe_clk_low)
    else $error("data changed with clock high");
  a_busy_min: assert property (p_busy_min)
    else $error("write cycle too short");
  a_busy_max: assert property (p_busy_max)
    else $error("write cycle too long");
  a_busy_after_stop: assert property (p_busy_after_stop)
    else $error("write cycle without stop");
  a_stop_idle: assert property (p_stop_idle)
    else $error("no standby after stop");
  a_done_standby: assert property (p_done_standby)
    else $error("no standby after write cycle");
  a_drive_selected: assert property (p_drive_selected)
    else $error("data driven while idle");
endmodule
bind serial_eeprom_bus_slave eeprom_slave_sva
  #(.WRITE_CYCLES(WRITE_CYCLES)) u_sva (.clk_sys(clk_sys),
  .resetn(resetn), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .write_protect(write_protect), .standby(standby),
  .write_busy(write_busy));

// ---- two_wire_master.sv ----
// behavioural bus master that makes the link clock
`timescale 1ns/10ps
module two_wire_master
(
  output logic scl,
  output logic sda_pull,
  input wire logic sda
);
  // idle bus: clock parked high, data released
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // start, or repeated start from a low clock
  task automatic start_c();
    // release data well after the clock fell, never with it
    #40 sda_pull = 1'b0;
    #40 scl = 1'b1;
    #40 sda_pull = 1'b1;
    #40 scl = 1'b0;
  endtask
  // one pulse per bit, data moved only while the clock is low
  task automatic bit_c(input logic b, output logic r);
    #40 sda_pull = !b;
    #40 scl = 1'b1;
    r = sda;
    #80 scl = 1'b0;
  endtask
  // msb first; ninth clock always released, so reads end in a nack
  task automatic xfer(input logic [7:0] d, output logic [7:0] q,
    output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--)
      bit_c(d[i], q[i]);
    bit_c(1'b1, a);
    ack = !a;
  endtask
  // stop leaves the bus idle and the clock still
  task automatic stop_c();
    #40 sda_pull = 1'b1;
    #40 scl = 1'b1;
    #40 sda_pull = 1'b0;
    #80;
  endtask
endmodule

// ---- testbench.sv ----
// self-checking bench for the serial memory slave
`timescale 1ns/10ps
module testbench;
  logic clk_sys = 1'b0; // system clock
  logic resetn = 1'b0; // power-on reset
  logic write_protect = 1'b0; // array write lock
  logic scl; // link clock from the master
  logic sda_pull; // master pulls data low
  logic sda_out;
  logic sda_oe; // device pulls data low
  logic standby;
  logic write_busy;
  wire sda_wire = !(sda_pull || sda_oe); // pulled-up wire
  int error_cnt = 0;
  int checked = 0;
  logic [7:0] seed = 8'h38; // lfsr state
  logic [7:0] page_exp [16]; // expected page contents
  logic [7:0] q;
  logic ack;
  logic [2:0] blk;
  logic [3:0] pos;
  logic [3:0] hi;
  logic [7:0] far_exp; // byte at the last location
  logic [7:0] zero_exp; // byte at location zero
  always #5 clk_sys = ~clk_sys;
  // short write cycle keeps the run brief
  serial_eeprom_bus_slave #(.WRITE_CYCLES(40)) u_dut (.clk_sys(clk_sys),
    .resetn(resetn), .scl(scl), .sda_in(sda_wire), .sda_out(sda_out),
    .sda_oe(sda_oe), .write_protect(write_protect), .standby(standby),
    .write_busy(write_busy));
  two_wire_master u_master (.scl(scl), .sda_pull(sda_pull),
    .sda(sda_wire));
  // next pseudo-random byte
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // slave address byte: type, block, direction
  function automatic logic [7:0] addr_byte(input logic [3:0] t,
    input logic rd);
    return {t, blk, rd};
  endfunction
  task automatic chk(input string what, input logic [7:0] exp,
    input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // start plus address byte, acknowledge compared
  task automatic open_f(input logic [7:0] a, input logic exp_ack);
    u_master.start_c();
    u_master.xfer(a, q, ack);
    chk("address ack", {7'h00, exp_ack}, {7'h00, ack});
  endtask
  // one written byte, always acknowledged
  task automatic send(input logic [7:0] d);
    u_master.xfer(d, q, ack);
    chk("byte ack", 8'h01, {7'h00, ack});
  endtask
  // current address read of one byte
  task automatic read_cur(input logic [3:0] t, input logic [7:0] exp);
    open_f(addr_byte(t, 1'b1), 1'b1);
    u_master.xfer(8'hFF, q, ack);
    chk("read data", exp, q);
    u_master.stop_c();
  endtask
  // bounded polling until the write cycle has ended
  task automatic poll();
    int n;
    n = 0;
    ack = 1'b0;
    while (!ack && n < 8)
    begin
      u_master.start_c();
      u_master.xfer(addr_byte(4'hA, 1'b0), q, ack);
      u_master.stop_c();
      n++;
    end
    chk("poll ack", 8'h01, {7'h00, ack});
    // a write cycle that never ends stops the run here
    if (!ack)
      give_verdict();
  endtask
  // one byte at a full location, then wait for the write cycle
  task automatic wr1(input logic [10:0] a, input logic [7:0] d);
    blk = a[10:8];
    open_f(addr_byte(4'hA, 1'b0), 1'b1);
    send(a[7:0]);
    send(d);
    u_master.stop_c();
    poll();
  endtask
  // hang guard
  initial
  begin
    #400000;
    error_cnt++;
    give_verdict();
  end
  initial
  begin
    repeat (10) @(negedge clk_sys);
    resetn = 1'b1;
    chk("standby", 8'h01, {7'h00, standby});
    repeat (5) @(negedge clk_sys);
    seed = lfsr(seed);
    blk = seed[2:0];
    pos = {1'b0, seed[5:3]}; // low offset: reads stay in the page
    hi = seed[7:4];
    // every device type; only the memory types answer
    for (int t = 0; t < 16; t++)
    begin
      open_f(addr_byte(4'(t), 1'b0), t == 10 || t == 11);
      u_master.stop_c();
    end
    // seventeen bytes: the last folds onto the first position
    open_f(addr_byte(4'hA, 1'b0), 1'b1);
    send({hi, pos});
    for (int i = 0; i < 17; i++)
    begin
      seed = lfsr(seed);
      page_exp[pos + 4'(i)] = seed;
      send(seed);
    end
    u_master.stop_c();
    chk("busy after stop", 8'h01, {7'h00, write_busy});
    chk("standby in write", 8'h00, {7'h00, standby});
    open_f(addr_byte(4'hA, 1'b0), 1'b0);
    u_master.stop_c();
    poll();
    read_cur(4'hA, page_exp[pos + 4'h1]);
    read_cur(4'hA, page_exp[pos + 4'h2]);
    // protected write is acknowledged but must not land
    @(negedge clk_sys);
    write_protect = 1'b1;
    open_f(addr_byte(4'hA, 1'b0), 1'b1);
    send({hi, pos + 4'h3});
    send(~page_exp[pos + 4'h3]);
    u_master.stop_c();
    poll();
    @(negedge clk_sys);
    write_protect = 1'b0;
    // a buffered byte cut off by a fresh start writes nothing
    open_f(addr_byte(4'hA, 1'b0), 1'b1);
    send({hi, pos + 4'h3});
    send(~page_exp[pos + 4'h3]);
    for (int i = 0; i < 4; i++)
      u_master.bit_c(1'b0, ack);
    u_master.start_c();
    u_master.stop_c();
    chk("busy after abort", 8'h00, {7'h00, write_busy});
    chk("standby after abort", 8'h01, {7'h00, standby});
    open_f(addr_byte(4'hA, 1'b0), 1'b1);
    send({hi, pos + 4'h3});
    u_master.stop_c();
    read_cur(4'hA, page_exp[pos + 4'h3]);
    // id page: a full page brings the counter back to its start
    open_f(addr_byte(4'hB, 1'b0), 1'b1);
    send({hi, pos});
    for (int i = 0; i < 16; i++)
    begin
      seed = lfsr(seed);
      page_exp[pos + 4'(i)] = seed;
      send(seed);
    end
    u_master.stop_c();
    poll();
    read_cur(4'hB, page_exp[pos]);
    // the last location wraps the counter to location zero
    seed = lfsr(seed);
    far_exp = seed;
    wr1(11'h7FF, far_exp);
    seed = lfsr(seed);
    zero_exp = seed;
    wr1(11'h000, zero_exp);
    wr1(11'h7FE, ~zero_exp);
    read_cur(4'hA, far_exp);
    read_cur(4'hA, zero_exp);
    give_verdict();
  end
endmodule
